/* dma_channel_irq_and_direction.sv */
/*
 Interrupt request flag and single-address direction control of one DMA
 channel mode register. Assumes software accesses arrive as one-cycle
 strobes from logic on clk_in, and event inputs are one-cycle pulses.
*/
// Operation
// (RULE1) Flag is bit 6, resets to 0; 1 means request pending, transfer ended.
// (RULE2) Transfer counter end request sets the flag.
// (RULE3) Source repeat area overflow sets the flag.
// (RULE4) Destination repeat area overflow sets the flag.
// (RULE5) Writing 1 to the transfer enable bit clears the flag.
// (RULE6) Writing 0 clears the flag only after it was read as 1.
// (RULE7) Count end enable bit 5, reset 0, gates counter end requests.
// (RULE8) Direction bit 4, reset 0: 0 source to device, 1 device to dest.
// (RULE9) Direction bit is ignored in dual address mode.
// (RULE10) Writing 1 to the flag leaves it unchanged.
// (RULE11) Interrupt request output is high while the flag is 1.
`timescale 1ns/1ps
`include "dma_dir_irq_params.svh"
module dma_channel_irq_and_direction
   import dma_dir_irq_pkg::*;
(
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                srst_in,
   // Mode register access
   input  wire logic                mode_wr_in,
   input  wire logic [`MODE_W-1:0]  mode_wdata_in,
   input  wire logic                mode_rd_in,
   input  wire logic                enable_wr_in,
   input  wire logic                channel_transfer_enable_in,
   input  wire logic                single_addr_mode_in,
   // Events
   input  wire irq_src_t            events_in,
   // Status and control outputs
   output logic [`MODE_W-1:0]       mode_rdata_out,
   output logic                     irq_out,
   output xfer_dir_t                dir_out,
   output logic                     dir_valid_out
);
   logic                flag_q;
   logic                flag_d;
   logic                ceie_q;
   logic                ceie_d;
   logic                dir_sel_q;
   logic                dir_sel_d;
   logic                armed_q;
   logic                armed_d;
   logic                set_ev;
   logic                clr_en;
   logic                clr_wr;
   logic [`MODE_W-1:0]  rdata_d;
   xfer_dir_t           dir_d;

   // Maps the direction bit onto its one-hot direction code.
   function automatic xfer_dir_t dir_decode(input logic sel);
      return sel ? DIR_DEV_TO_DST : DIR_SRC_TO_DEV;
   endfunction

   // Places one control bit at its position in the read-back word.
   function automatic logic [`MODE_W-1:0] place_bit(input logic bit_val,
                                                   input int   pos);
      return `MODE_W'(bit_val) << pos;
   endfunction

   // Counter end only counts while its enable holds.
   assign set_ev = (events_in.count_end & ceie_q) // RULE2 RULE7
                 | events_in.src_ovf // RULE3
                 | events_in.dst_ovf; // RULE4
   assign clr_en = enable_wr_in & channel_transfer_enable_in; // RULE5
   // Reading a 0 does not arm the clear, so a stale read cannot lose an event.
   assign clr_wr = mode_wr_in & ~mode_wdata_in[`FLAG_BIT] & armed_q; // RULE6
   // Set wins over either clear, so an event in a clear cycle is never lost.
   assign flag_d = set_ev | (flag_q & ~clr_en & ~clr_wr); // RULE10
   // Any write disarms, and the arm is lost once the flag falls.
   assign armed_d = mode_wr_in ? 1'b0
                  : (mode_rd_in & flag_q) ? 1'b1 : armed_q & flag_q; // RULE6
   assign ceie_d = mode_wr_in ? mode_wdata_in[`CNT_IE_BIT] : ceie_q; // RULE7
   assign dir_sel_d = mode_wr_in ? mode_wdata_in[`DIR_BIT] // RULE8
                    : dir_sel_q;
   assign dir_d = dir_decode(dir_sel_d); // RULE8
   assign rdata_d = place_bit(flag_d, `FLAG_BIT)
                  | place_bit(ceie_d, `CNT_IE_BIT)
                  | place_bit(dir_sel_d, `DIR_BIT);

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         flag_q         <= `FLAG_RST; // RULE1
         ceie_q         <= `CNT_IE_RST; // RULE7
         dir_sel_q      <= `DIR_RST; // RULE8
         armed_q        <= 1'b0;
         irq_out        <= 1'b0;
         dir_out        <= DIR_SRC_TO_DEV;
         dir_valid_out  <= 1'b0;
         mode_rdata_out <= '0;
      end
      else
      begin
         flag_q         <= flag_d;
         ceie_q         <= ceie_d;
         dir_sel_q      <= dir_sel_d;
         armed_q        <= armed_d;
         irq_out        <= flag_d; // RULE11
         dir_out        <= dir_d; // RULE8
         // Direction is only meaningful while single address mode holds.
         dir_valid_out  <= single_addr_mode_in; // RULE9
         mode_rdata_out <= rdata_d;
      end
   end

   // Any event that is let through raises the flag on the next edge.
   property p_set_flag;
      @(posedge clk_in) disable iff (srst_in)
      set_ev |=> flag_q;
   endproperty
   a_set_flag: assert property (p_set_flag) // RULE2
      else $error("flag not set");

   // A masked counter end alone leaves a clear flag clear.
   property p_no_set_disabled;
      @(posedge clk_in) disable iff (srst_in)
      (!flag_q && events_in == irq_src_t'(3'h4) && !ceie_q) |=> !flag_q;
   endproperty
   a_no_set_disabled: assert property (p_no_set_disabled) // RULE7
      else $error("masked end set flag");

   // Either repeat area overflow raises the flag whatever the enable.
   property p_ovf_set;
      @(posedge clk_in) disable iff (srst_in)
      (events_in.src_ovf || events_in.dst_ovf) |=> flag_q;
   endproperty
   a_ovf_set: assert property (p_ovf_set) // RULE3 RULE4
      else $error("overflow lost");

   // Writing 1 to the transfer enable clears the flag.
   property p_en_clear;
      @(posedge clk_in) disable iff (srst_in)
      (clr_en && !set_ev) |=> !flag_q;
   endproperty
   a_en_clear: assert property (p_en_clear) // RULE5
      else $error("enable write kept flag");

   // A read of 1 followed directly by a write of 0 clears the flag.
   sequence s_read_one;
      mode_rd_in && flag_q && !mode_wr_in;
   endsequence
   sequence s_write_zero;
      mode_wr_in && !mode_wdata_in[`FLAG_BIT] && !set_ev;
   endsequence
   property p_rd_then_clear;
      @(posedge clk_in) disable iff (srst_in)
      s_read_one ##1 s_write_zero |=> !flag_q;
   endproperty
   a_rd_then_clear: assert property (p_rd_then_clear) // RULE6
      else $error("armed clear failed");

   // Without a prior read of 1 only a transfer enable write can clear the flag.
   property p_unarmed_keep;
      @(posedge clk_in) disable iff (srst_in)
      (flag_q && !armed_q && !clr_en) |=> flag_q;
   endproperty
   a_unarmed_keep: assert property (p_unarmed_keep) // RULE6
      else $error("unarmed clear");

   // Every write disarms the clear, the clearing write included.
   property p_write_disarms;
      @(posedge clk_in) disable iff (srst_in)
      mode_wr_in |=> !armed_q;
   endproperty
   a_write_disarms: assert property (p_write_disarms) // RULE6
      else $error("write left clear armed");

   // Software can never raise the flag.
   property p_w1_no_set;
      @(posedge clk_in) disable iff (srst_in)
      (!flag_q && !set_ev) |=> !flag_q;
   endproperty
   a_w1_no_set: assert property (p_w1_no_set) // RULE10
      else $error("flag set by write");

   // A write of 1 to a set flag leaves it set.
   property p_w1_keep;
      @(posedge clk_in) disable iff (srst_in)
      (flag_q && mode_wr_in && mode_wdata_in[`FLAG_BIT] && !clr_en)
         |=> flag_q;
   endproperty
   a_w1_keep: assert property (p_w1_keep) // RULE10
      else $error("write of one cleared flag");

   // The request output mirrors the flag at every edge.
   property p_irq_follows;
      @(posedge clk_in) disable iff (srst_in)
      ##1 (irq_out == flag_q);
   endproperty
   a_irq_follows: assert property (p_irq_follows) // RULE11
      else $error("irq mismatch");

   // Reset clears the flag, both control bits, irq_out and the read-back word, and sets dir_out to DIR_SRC_TO_DEV.
   property p_reset_clear;
      @(posedge clk_in)
      srst_in |=> (!flag_q && !ceie_q && !dir_sel_q && !irq_out
                   && mode_rdata_out == '0 && dir_out == DIR_SRC_TO_DEV);
   endproperty
   a_reset_clear: assert property (p_reset_clear) // RULE1
      else $error("reset left state");

   // The read-back word carries the flag in its own bit position.
   property p_rdata_flag;
      @(posedge clk_in) disable iff (srst_in)
      1'b1 |=> (mode_rdata_out[`FLAG_BIT] == flag_q);
   endproperty
   a_rdata_flag: assert property (p_rdata_flag) // RULE1
      else $error("read-back flag wrong");

   // The direction code follows the direction bit of the last write.
   property p_dir;
      @(posedge clk_in) disable iff (srst_in)
      mode_wr_in |=> (dir_out == dir_decode($past(mode_wdata_in[`DIR_BIT])));
   endproperty
   a_dir: assert property (p_dir) // RULE8
      else $error("direction wrong");

   // The valid flag follows the address mode, so dual mode hides direction.
   property p_dir_valid;
      @(posedge clk_in) disable iff (srst_in)
      1'b1 |=> (dir_valid_out == $past(single_addr_mode_in));
   endproperty
   a_dir_valid: assert property (p_dir_valid) // RULE9
      else $error("direction valid wrong");
endmodule // dma_channel_irq_and_direction

/* dma_channel_irq_and_direction_tb.sv */
/* Self-checking bench for the channel flag and direction logic.
   Assumes the package and the event producer model are compiled first. */
`timescale 1ns/1ps
module dma_channel_irq_and_direction_tb;
   import dma_dir_irq_pkg::*;
   logic       clk_in = 0, srst_in = 1, mode_wr_in = 0, mode_rd_in = 0;
   logic       enable_wr_in = 0, channel_transfer_enable_in = 0;
   logic       single_addr_mode_in = 1, irq_out, dir_valid_out;
   logic [7:0] mode_wdata_in = 8'h00, mode_rdata_out;
   xfer_dir_t  dir_out;
   irq_src_t   fire = '0, events_in;
   int         miscompares = 0, cmp_count = 0, cycles = 0;
   always #2.5 clk_in = ~clk_in;
   // The whole run needs well under 200 cycles.
   always @(posedge clk_in)
      if (++cycles > 3000)
         final_report(1'b1);
   dma_event_source src (.clk_in, .srst_in, .fire_in(fire),
      .events_out(events_in));
   dma_channel_irq_and_direction uut (.clk_in, .srst_in, .mode_wr_in,
      .mode_wdata_in, .mode_rd_in, .enable_wr_in, .single_addr_mode_in,
      .channel_transfer_enable_in, .events_in, .mode_rdata_out, .irq_out,
      .dir_out, .dir_valid_out);
   task chk(input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task look(input logic [7:0] exp);
      @(negedge clk_in);
      chk(mode_rdata_out, exp);
      chk({7'h00, irq_out}, {7'h00, exp[6]});
   endtask
   task p(input logic w, r, e, input logic [7:0] d);
      @(posedge clk_in);
      {mode_wr_in, mode_rd_in, enable_wr_in} <= {w, r, e};
      channel_transfer_enable_in <= e;
      mode_wdata_in <= d;
      @(posedge clk_in);
      {mode_wr_in, mode_rd_in, enable_wr_in} <= 3'b000;
   endtask
   task rw(input logic [7:0] d);
      @(posedge clk_in);
      {mode_wr_in, mode_rd_in} <= 2'h1;
      @(posedge clk_in);
      {mode_wr_in, mode_rd_in} <= 2'h2;
      mode_wdata_in <= d;
      @(posedge clk_in);
      mode_wr_in <= 1'b0;
   endtask
   task ev(input irq_src_t s);
      @(posedge clk_in);
      fire <= s;
      @(posedge clk_in);
      fire <= '0;
      @(posedge clk_in);
   endtask
   task t_flag;
      ev(3'b010);
      look(8'h40);
      p(1, 0, 0, 8'h00);
      look(8'h40);
      p(0, 1, 0, 8'h00);
      p(1, 0, 0, 8'h40);
      look(8'h40);
      rw(8'h00);
      look(8'h00);
      ev(3'b001);
      look(8'h40);
      p(0, 0, 1, 8'h00);
      look(8'h00);
      $display("flag test done");
   endtask
   task t_count;
      ev(3'b100);
      look(8'h00);
      p(1, 0, 0, 8'h20);
      ev(3'b100);
      look(8'h60);
      $display("count test done");
   endtask
   task t_dir;
      p(1, 0, 0, 8'h10);
      look(8'h50);
      chk({6'h00, dir_out}, {6'h00, DIR_DEV_TO_DST});
      chk({7'h00, dir_valid_out}, 8'h01);
      p(1, 0, 0, 8'h00);
      single_addr_mode_in <= 1'b0;
      @(posedge clk_in);
      look(8'h40);
      chk({6'h00, dir_out}, {6'h00, DIR_SRC_TO_DEV});
      chk({7'h00, dir_valid_out}, 8'h00);
      $display("direction test done");
   endtask
   task t_reset;
      p(1, 0, 0, 8'h30);
      look(8'h70);
      @(posedge clk_in);
      srst_in <= 1'b1;
      @(posedge clk_in);
      srst_in <= 1'b0;
      look(8'h00);
      chk({6'h00, dir_out}, {6'h00, DIR_SRC_TO_DEV});
      ev(3'h2);
      look(8'h40);
      p(0, 1, 0, 8'h00);
      p(1, 0, 0, 8'h00);
      look(8'h00);
      $display("reset test done");
   endtask
   task final_report(input bit hung);
      miscompares += hung;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clk_in);
      srst_in <= 1'b0;
      look(8'h00);
      t_flag;
      t_count;
      t_dir;
      t_reset;
      final_report(1'b0);
   end
endmodule // dma_channel_irq_and_direction_tb

/* dma_dir_irq_params.svh */
/*
 Bit positions, reset values and sizes for the channel flag and direction
 logic. Assumes inclusion from the package and the design file.
*/
`ifndef DMA_DIR_IRQ_PARAMS_SVH
`define DMA_DIR_IRQ_PARAMS_SVH
`define FLAG_BIT      6
`define CNT_IE_BIT    5
`define DIR_BIT       4
`define MODE_W        8
`define FLAG_RST      1'b0
`define CNT_IE_RST    1'b0
`define DIR_RST       1'b0
`endif

/* dma_dir_irq_pkg.sv */
/*
 Types for the channel flag and direction logic.
 Assumes the parameter header is on the include path.
*/
`include "dma_dir_irq_params.svh"
package dma_dir_irq_pkg;
   typedef enum logic [1:0] {
      DIR_SRC_TO_DEV = 2'b01,
      DIR_DEV_TO_DST = 2'b10
   } xfer_dir_t;
   typedef struct packed {
      logic count_end;
      logic src_ovf;
      logic dst_ovf;
   } irq_src_t;
endpackage

/* dma_event_source.sv */
/* Event producer beside the DMA channel: one-cycle event pulses.
   Assumes requests are driven just after rising edges of clk_in. */
`timescale 1ns/1ps
module dma_event_source
   import dma_dir_irq_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_in,
   input  wire logic     srst_in,
   // Request and event
   input  wire irq_src_t fire_in,
   output irq_src_t      events_out
);
   // Registered, so an event lands one cycle after its request.
   always_ff @(posedge clk_in)
      events_out <= srst_in ? '0 : fire_in;
endmodule // dma_event_source
